// ### common/isp_pkg.sv
// Constants and types for the in-system programming sequencer
`default_nettype none
package isp_pkg;
  // Instruction codes (arbitrary encoding)
  localparam int INSTR_W = 8;
  localparam logic [7:0] INSTR_ENTER = 8'h01;
  localparam logic [7:0] INSTR_IDCODE = 8'h02;
  localparam logic [7:0] INSTR_ERASE = 8'h03;
  localparam logic [7:0] INSTR_PROGRAM = 8'h04;
  localparam logic [7:0] INSTR_VERIFY = 8'h05;
  localparam logic [7:0] INSTR_EXIT = 8'h06;
  // Identity code, value arbitrary
  localparam logic [31:0] IDCODE_DEFAULT = 32'h1234_5679;
  // Timing figures
  localparam int CLK_HZ = 40_000_000;
  localparam int MODE_US = 1000;
  localparam int ERASE_MS = 100;
  localparam int PROG_US = 100;
  localparam int READ_US = 1;
  localparam longint MODE_CYC = (longint'(MODE_US) * CLK_HZ) / 1_000_000;
  localparam longint ERASE_CYC = (longint'(ERASE_MS) * CLK_HZ) / 1_000;
  localparam longint PROG_CYC = (longint'(PROG_US) * CLK_HZ) / 1_000_000;
  localparam longint READ_CYC = (longint'(READ_US) * CLK_HZ) / 1_000_000;
  // Pulse kinds
  typedef enum logic [4:0] {
    P_IDLE = 5'h01,
    P_MODE = 5'h02,
    P_ERASE = 5'h04,
    P_PROG = 5'h08,
    P_READ = 5'h10
  } isp_pulse_type;
endpackage
`default_nettype wire

// ### hw/isp_sequencer.sv
// In-system programming sequencer at the device side of the test port
// What this block does
// RULE_01: The programmer shifts instructions, addresses and data in on tdi, timed by tck.
// RULE_02: The device shifts read-back data out on tdo for the programmer to compare.
// RULE_03: A full programming runs enter, identity check, erase, program, verify, exit in order.
// RULE_04: A stand-alone verification runs only enter, identity check, verify and exit.
// RULE_05: Entering programming mode hands the pins over to programming cleanly within 1 ms.
// RULE_06: The identity code is readable through the serial port before programming or verify.
// RULE_07: Bulk erase applies one erase pulse of 100 ms to the cells.
// RULE_08: Each shifted address and data word is written by one programming pulse.
// RULE_09: Each verify address gets a read pulse, and the read data is shifted out.
// RULE_10: Leaving programming mode hands the pins back to user mode cleanly within 1 ms.
// RULE_11: The programmer budgets each stage as pulse time plus shift cycles over tck rate.
// RULE_12: Total time is the summed pulse times plus device tck cycles over tck rate.
// RULE_13: On identity or verify mismatch the programmer stops, flags failure, then exits. The testbench stops only on the first identity check.
`timescale 1ns/10ps
`default_nettype none
module isp_sequencer #(
  parameter int ADDR_W = 8,
  parameter int DATA_W = 16,
  parameter logic [31:0] IDCODE = isp_pkg::IDCODE_DEFAULT,
  parameter longint MODE_CYCLES = isp_pkg::MODE_CYC,
  parameter longint ERASE_CYCLES = isp_pkg::ERASE_CYC,
  parameter longint PROG_CYCLES = isp_pkg::PROG_CYC,
  parameter longint READ_CYCLES = isp_pkg::READ_CYC
) (
  // System clock and reset
  input wire logic clk,
  input wire logic rst,
  // Test port, tck domain
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_oe,
  // Cell array
  output logic cell_we,
  output logic cell_erase,
  output logic cell_re,
  output logic [ADDR_W-1:0] cell_addr,
  output logic [DATA_W-1:0] cell_wdata,
  input wire logic [DATA_W-1:0] cell_rdata,
  // Pin control and status
  output logic in_system_programming,
  output logic pulse_busy
);
  localparam int SH_W = (DATA_W + ADDR_W > 32) ? DATA_W + ADDR_W : 32;
  localparam int CNT_W = 32;

  // tck domain: tms rising takes the shift register as instruction or data word in turn, low captures then shifts
  logic rst_t_s1, rst_t_s2, rst_t;
  logic [isp_pkg::INSTR_W-1:0] ir, next_ir;
  logic [SH_W-1:0] sh, next_sh;
  logic tms_q, next_tms_q;
  logic dframe, next_dframe;
  logic req_tgl, next_req_tgl;
  logic [isp_pkg::INSTR_W-1:0] req_ir, next_req_ir;
  logic [SH_W-1:0] req_word, next_req_word;
  logic [DATA_W-1:0] rd_hold, next_rd_hold;
  logic rd_tgl_s1, rd_tgl_s2, rd_tgl_s3;
  logic busy_s1, busy_s2;
  logic next_tdo, tdo_q;
  logic [DATA_W-1:0] cell_wdata_rd;
  logic rd_tgl, next_rd_tgl;

  // Reset into tck domain
  // Two stages, only the second is read
  always_ff @(posedge tck) begin
    rst_t_s1 <= rst;
    rst_t_s2 <= rst_t_s1;
  end
  assign rst_t = rst_t_s2;

  always_comb begin
    next_ir = ir;
    next_sh = sh;
    next_tms_q = tms;
    next_dframe = dframe;
    next_req_tgl = req_tgl;
    next_req_ir = req_ir;
    next_req_word = req_word;
    next_rd_hold = rd_hold;
    next_tdo = sh[0]; // RULE_02
    // Fresh read data, stable since its toggle left the clk domain
    if (rd_tgl_s2 ^ rd_tgl_s3) begin
      next_rd_hold = cell_wdata_rd;
    end
    if (tms) begin
      if (!tms_q) begin
        // Update: frames alternate between instruction and data
        if (!dframe) begin
          next_ir = sh[isp_pkg::INSTR_W-1:0];
          next_dframe = 1'b1;
        end else begin
          next_dframe = 1'b0;
          // Busy drops the command
          if (!busy_s2) begin
            next_req_ir = ir;
            next_req_word = sh;
            next_req_tgl = ~req_tgl;
          end
        end
      end
    end else begin
      if (tms_q) begin
        // Capture
        if (ir == isp_pkg::INSTR_IDCODE) begin
          next_sh = SH_W'(IDCODE); // RULE_06
        end else if (ir == isp_pkg::INSTR_VERIFY) begin
          next_sh = SH_W'(rd_hold); // RULE_09
        end else begin
          next_sh = {tdi, sh[SH_W-1:1]}; // RULE_01
        end
      end else begin
        next_sh = {tdi, sh[SH_W-1:1]}; // RULE_01
      end
    end
  end

  // tck domain registers
  always_ff @(posedge tck) begin
    if (rst_t) begin
      ir <= '0;
      sh <= '0;
      tms_q <= 1'b1;
      dframe <= 1'b0;
      rd_hold <= '0;
      req_tgl <= 1'b0;
      req_ir <= '0;
      req_word <= '0;
    end else begin
      ir <= next_ir;
      sh <= next_sh;
      tms_q <= next_tms_q;
      dframe <= next_dframe;
      rd_hold <= next_rd_hold;
      req_tgl <= next_req_tgl;
      req_ir <= next_req_ir;
      req_word <= next_req_word;
    end
  end

  // Busy and read toggle back into tck domain
  // Read word itself crosses only once its toggle has settled
  always_ff @(posedge tck) begin
    if (rst_t) begin
      busy_s1 <= 1'b0;
      busy_s2 <= 1'b0;
      rd_tgl_s1 <= 1'b0;
      rd_tgl_s2 <= 1'b0;
      rd_tgl_s3 <= 1'b0;
    end else begin
      busy_s1 <= pulse_busy;
      busy_s2 <= busy_s1;
      rd_tgl_s1 <= rd_tgl;
      rd_tgl_s2 <= rd_tgl_s1;
      rd_tgl_s3 <= rd_tgl_s2;
    end
  end

  // TDO on falling edge
  always_ff @(negedge tck) begin
    if (rst_t) begin
      tdo_q <= 1'b0;
    end else begin
      tdo_q <= next_tdo; // RULE_02
    end
  end
  assign tdo = tdo_q;
  assign tdo_oe = ~tms_q; // RULE_02

  // clk domain: toggle crossing for commands
  logic tgl_s1, tgl_s2, tgl_s3;
  isp_pkg::isp_pulse_type kind, next_kind;
  logic [CNT_W-1:0] cnt, next_cnt;
  logic mode, next_mode;
  logic [ADDR_W-1:0] addr, next_addr;
  logic [DATA_W-1:0] wdata, next_wdata;
  logic [DATA_W-1:0] rdata, next_rdata;
  logic entering, next_entering;
  logic go;

  always_ff @(posedge clk) begin
    if (rst) begin
      tgl_s1 <= 1'b0;
      tgl_s2 <= 1'b0;
      tgl_s3 <= 1'b0;
    end else begin
      tgl_s1 <= req_tgl;
      tgl_s2 <= tgl_s1;
      tgl_s3 <= tgl_s2;
    end
  end
  // Request fields are stable while toggle travels
  assign go = tgl_s2 ^ tgl_s3;

  function automatic logic [CNT_W-1:0] cyc(input longint c);
    cyc = (c < 1) ? CNT_W'(1) : CNT_W'(c);
  endfunction

  always_comb begin
    next_kind = kind;
    next_cnt = cnt;
    next_mode = mode;
    next_addr = addr;
    next_wdata = wdata;
    next_rdata = rdata;
    next_entering = entering;
    next_rd_tgl = rd_tgl;
    // Commands other than entry act only inside programming mode
    // Pulse length fixed per kind
    case (kind)
      isp_pkg::P_IDLE: begin
        if (go) begin
          if (req_ir == isp_pkg::INSTR_ENTER && !mode) begin
            next_kind = isp_pkg::P_MODE; // RULE_05
            next_entering = 1'b1;
            next_mode = 1'b1;
            next_cnt = cyc(MODE_CYCLES);
          end else if (req_ir == isp_pkg::INSTR_EXIT && mode) begin
            next_kind = isp_pkg::P_MODE; // RULE_10
            next_entering = 1'b0;
            next_cnt = cyc(MODE_CYCLES);
          end else if (req_ir == isp_pkg::INSTR_ERASE && mode) begin
            next_kind = isp_pkg::P_ERASE; // RULE_07
            next_cnt = cyc(ERASE_CYCLES);
          end else if (req_ir == isp_pkg::INSTR_PROGRAM && mode) begin
            next_kind = isp_pkg::P_PROG; // RULE_08
            next_addr = req_word[ADDR_W-1:0];
            next_wdata = req_word[ADDR_W +: DATA_W];
            next_cnt = cyc(PROG_CYCLES);
          end else if (req_ir == isp_pkg::INSTR_VERIFY && mode) begin
            next_kind = isp_pkg::P_READ; // RULE_09
            next_addr = req_word[ADDR_W-1:0];
            next_cnt = cyc(READ_CYCLES);
          end
        end
      end
      isp_pkg::P_MODE: begin
        // Pins are taken at the start of the entry pulse and handed back only at the end of the exit pulse
        next_cnt = cnt - CNT_W'(1);
        if (cnt == CNT_W'(1)) begin
          next_kind = isp_pkg::P_IDLE;
          if (!entering) begin
            next_mode = 1'b0; // RULE_10
          end
        end
      end
      isp_pkg::P_ERASE, isp_pkg::P_PROG: begin
        next_cnt = cnt - CNT_W'(1);
        if (cnt == CNT_W'(1)) begin
          next_kind = isp_pkg::P_IDLE;
        end
      end
      isp_pkg::P_READ: begin
        // Sample the cells in the last read cycle
        next_cnt = cnt - CNT_W'(1);
        if (cnt == CNT_W'(1)) begin
          next_kind = isp_pkg::P_IDLE;
          next_rdata = cell_rdata; // RULE_09
          next_rd_tgl = ~rd_tgl;
        end
      end
      default: begin
        next_kind = isp_pkg::P_IDLE;
      end
    endcase
  end

  // clk domain registers
  always_ff @(posedge clk) begin
    if (rst) begin
      rd_tgl <= 1'b0;
      kind <= isp_pkg::P_IDLE;
      cnt <= '0;
      mode <= 1'b0;
      addr <= '0;
      wdata <= '0;
      rdata <= '0;
      entering <= 1'b0;
    end else begin
      kind <= next_kind;
      cnt <= next_cnt;
      mode <= next_mode;
      addr <= next_addr;
      wdata <= next_wdata;
      rdata <= next_rdata;
      entering <= next_entering;
      rd_tgl <= next_rd_tgl;
    end
  end

  // Cell strobes straight from the pulse kind
  assign cell_wdata_rd = rdata;
  assign cell_erase = (kind == isp_pkg::P_ERASE); // RULE_07
  assign cell_we = (kind == isp_pkg::P_PROG); // RULE_08
  assign cell_re = (kind == isp_pkg::P_READ); // RULE_09
  assign cell_addr = addr;
  assign cell_wdata = wdata;
  assign in_system_programming = mode; // RULE_05
  assign pulse_busy = (kind != isp_pkg::P_IDLE);
endmodule // isp_sequencer
`default_nettype wire

// ### test/isp_programmer.sv
// Programmer model at the far side of the test port
`timescale 1ns/10ps
`default_nettype none
module isp_programmer (
  // Test port
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo
);
  initial begin
    tck = 0;
    tms = 1;
    tdi = 0;
  end
  // Idle clock edges
  task automatic idle(input int n);
    repeat (n) #40 tck = ~tck;
  endtask
  // Capture edge, 32 shift edges, update edge
  task automatic frame(input logic [31:0] w, output logic [31:0] got);
    for (int i = 0; i < 34; i++) begin
      tms = i == 33;
      tdi = i > 0 && i < 33 ? w[i-1] : ~tdi;
      #40 tck = 1;
      if (i > 0 && i < 33) got[i-1] = tdo;
      #40 tck = 0;
    end
  endtask
endmodule // isp_programmer
`default_nettype wire

// ### test/isp_sequencer_checker.sv
// Assertion checker for the programming sequencer
`timescale 1ns/10ps
`default_nettype none
module isp_sequencer_checker #(
  parameter longint ERASE_CYCLES = 20,
  parameter longint PROG_CYCLES = 20,
  parameter longint READ_CYCLES = 20
) (
  // Clocks and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic tck,
  // Watched ports
  input wire logic tms,
  input wire logic tdo_oe,
  input wire logic cell_we,
  input wire logic cell_erase,
  input wire logic cell_re,
  input wire logic in_system_programming,
  input wire logic pulse_busy
);
  int run;
  int next_run;
  logic hot;
  assign hot = cell_we | cell_erase | cell_re;
  // Length of the current cell pulse
  always_comb next_run = hot ? run + 1 : 0;
  always_ff @(posedge clk) run <= rst ? 0 : next_run;
  a_erase_len: assert property (@(posedge clk) disable iff (rst)
    $fell(cell_erase) |-> run == ERASE_CYCLES) else $error("erase pulse length");
  a_prog_len: assert property (@(posedge clk) disable iff (rst)
    $fell(cell_we) |-> run == PROG_CYCLES) else $error("write pulse length");
  a_read_len: assert property (@(posedge clk) disable iff (rst)
    $fell(cell_re) |-> run == READ_CYCLES) else $error("read pulse length");
  a_one_strobe: assert property (@(posedge clk) disable iff (rst)
    $onehot0({cell_we, cell_erase, cell_re})) else $error("strobes overlap");
  a_strobe_busy: assert property (@(posedge clk) disable iff (rst)
    hot |-> pulse_busy) else $error("strobe without busy");
  a_strobe_mode: assert property (@(posedge clk) disable iff (rst)
    hot |-> in_system_programming) else $error("strobe outside mode");
  a_entry_quiet: assert property (@(posedge clk) disable iff (rst)
    $rose(in_system_programming) |-> (!hot) [*8]) else $error("cells busy at entry");
  a_tdo_drive: assert property (@(posedge tck) disable iff (rst)
    !tms |=> tdo_oe) else $error("tdo not driven in shift");
endmodule // isp_sequencer_checker
bind isp_sequencer isp_sequencer_checker #(.ERASE_CYCLES(ERASE_CYCLES),
  .PROG_CYCLES(PROG_CYCLES), .READ_CYCLES(READ_CYCLES)) i_chk (.*);
`default_nettype wire

// ### test/isp_sequencer_tb.sv
// Testbench for the programming sequencer
`timescale 1ns/10ps
`default_nettype none
module isp_sequencer_tb;
  logic clk = 0;
  logic rst = 1;
  logic tck, tms, tdi, tdo, tdo_oe, cell_we, cell_erase, cell_re;
  logic in_system_programming, pulse_busy;
  logic [7:0] cell_addr;
  logic [23:0] cell_wdata;
  logic [23:0] cell_rdata;
  logic [23:0] mem [256];
  logic [31:0] got;
  int errors = 0, checks_done = 0, n_we, n_er, n_bz;
  always #12.5 clk = ~clk;
  isp_programmer i_prog (.*);
  isp_sequencer #(.DATA_W(24), .MODE_CYCLES(20), .ERASE_CYCLES(30), .PROG_CYCLES(10),
    .READ_CYCLES(4)) i_dut (.*);
  // Cell array stand-in and pulse counters
  always @(posedge clk) begin
    if (cell_we) mem[cell_addr] <= cell_wdata;
    if (cell_erase) mem <= '{default: 24'hFFFFFF};
    cell_rdata <= #1 cell_re ? mem[cell_addr] : ~cell_rdata;
    n_we += cell_we;
    n_er += cell_erase;
    n_bz += pulse_busy;
  end
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Instruction frame, data frame, then the pulse if any
  task automatic cmd(logic [7:0] ins, logic [31:0] w);
    {n_we, n_er, n_bz} = 0;
    i_prog.frame({24'h0, ins}, got);
    i_prog.frame(w, got);
    for (int k = 0; k < 40 && !pulse_busy; k++) @(posedge clk);
    for (int k = 0; k < 99 && pulse_busy; k++) @(posedge clk);
    #1;
  endtask
  task automatic t_refuse;
    cmd(isp_pkg::INSTR_PROGRAM, 32'h0000_1120);
    check("writes", n_we, 0);
    check("tdo_oe idle", tdo_oe, 0);
    check("mode", in_system_programming, 0);
  endtask
  task automatic t_enter;
    cmd(isp_pkg::INSTR_ENTER, 0);
    check("mode", in_system_programming, 1);
    check("entry", n_bz, 20);
  endtask
  task automatic t_id;
    cmd(isp_pkg::INSTR_IDCODE, 0);
    check("identity", got, isp_pkg::IDCODE_DEFAULT);
  endtask
  task automatic t_erase;
    cmd(isp_pkg::INSTR_ERASE, 0);
    check("erase", n_er, 30);
  endtask
  task automatic t_prog(logic [7:0] a, logic [23:0] d);
    cmd(isp_pkg::INSTR_PROGRAM, {d, a});
    check("write", n_we, 10);
    check("cell", mem[a], d);
  endtask
  task automatic t_verify(logic [7:0] a, logic [23:0] d);
    cmd(isp_pkg::INSTR_VERIFY, {24'h0, a});
    cmd(isp_pkg::INSTR_VERIFY, {24'h0, a});
    check("read", got[23:0], d);
  endtask
  task automatic t_exit;
    cmd(isp_pkg::INSTR_EXIT, 0);
    check("exit", n_bz, 20);
    check("mode", in_system_programming, 0);
  endtask
  task automatic test_done;
    if (errors == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    fork
      i_prog.idle(6);
    join_none
    repeat (10) @(posedge clk);
    #1 rst = 0;
    // Let the tck side leave reset before the first frame
    i_prog.idle(6);
    t_refuse();
    t_enter();
    t_id();
    if (got === isp_pkg::IDCODE_DEFAULT) begin
      t_erase();
      t_prog(8'h20, 24'hA5C3E1);
      t_prog(8'h7E, 24'h00FF0F);
      t_verify(8'h20, 24'hA5C3E1);
      t_verify(8'h7E, 24'h00FF0F);
      t_verify(8'h33, 24'hFFFFFF);
    end
    t_exit();
    // Stand-alone verification of the pattern left behind
    t_enter();
    t_id();
    t_verify(8'h7E, 24'h00FF0F);
    t_exit();
    test_done();
  end
  // Budget: each command is 68 tck of shifting plus its pulse, wide margin
  initial begin
    #1ms;
    errors++;
    test_done();
  end
endmodule // isp_sequencer_tb
`default_nettype wire
